// *** pkg/fsfe_pkg.sv ***
// Function
// - Empty flag low when queue holds nothing
// - Empty flag updated on the one clock shared by both sides
// - Near-empty low within empty-side offset
// - Empty offset default 31, 63 or 127
// - Near-full low within full-side offset
// - Full offset default 31, 63 or 127
// - Half flag low above half occupancy
// - Write chain pulse on last write
// - Read chain pulse on last read
// - Read data eighteen bits wide
// - Reset clears pointers, sets flag levels
// - Full flag low when full, refuses writes
// - Load low accesses offset registers
package fsfe_pkg;
  localparam int          DATA_W     = 18;
  localparam int          DEPTH      = 256;
  localparam int          ADDR_W     = 8;
  localparam int          CNT_W      = 9;
  localparam int          OFS_W      = 12;
  localparam logic [11:0] OFS_RST_256  = 12'h001F;
  localparam logic [11:0] OFS_RST_512  = 12'h003F;
  localparam logic [11:0] OFS_RST_BIG  = 12'h007F;
  localparam logic [8:0]  CNT_ZERO   = 9'h000;
  localparam logic [8:0]  CNT_FULL   = 9'h100;
  localparam logic [8:0]  CNT_HALF   = 9'h080;
  localparam logic [7:0]  PTR_LAST   = 8'hFF;
  localparam logic [7:0]  PTR_FIRST  = 8'h00;
  localparam int          BUF_DEPTH  = 2;

  function automatic logic [11:0] ofs_default(input int depth);
    if (depth == 256) begin
      return OFS_RST_256;
    end else if (depth == 512) begin
      return OFS_RST_512;
    end else begin
      return OFS_RST_BIG;
    end
  endfunction
endpackage

// *** logic/fsfe_fifo.sv ***
`timescale 1ns/1ps
module fsfe_fifo (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       push_en_n_i,
  input  wire logic [fsfe_pkg::DATA_W-1:0] push_data_i,
  input  wire logic                       pop_en_n_i,
  input  wire logic                       offset_load_n_i,
  input  wire logic                       wr_chain_in_n_i,
  input  wire logic                       rd_chain_in_n_i,
  input  wire logic                       chain_head_n_i,
  output logic                            pop_valid_o,
  input  wire logic                       pop_ready_i,
  output logic [fsfe_pkg::DATA_W-1:0]     pop_data_o,
  output logic                            queue_empty_n_o,
  output logic                            queue_full_n_o,
  output logic                            near_empty_n_o,
  output logic                            near_full_n_o,
  output logic                            wr_chain_out_or_half_n_o,
  output logic                            rd_chain_out_n_o
);
  import fsfe_pkg::*;

  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] wptr_reg;
  logic [ADDR_W-1:0] rptr_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic [OFS_W-1:0]  ofs_empty_reg;
  logic [OFS_W-1:0]  ofs_full_reg;
  logic              ofs_wsel_reg;
  logic              ofs_rsel_reg;
  logic              chain_mode_reg;
  logic              wchain_reg;
  logic              rchain_reg;
  logic [DATA_W-1:0] buf_data [BUF_DEPTH];
  logic [1:0]        buf_cnt_reg;
  logic              buf_wr_reg;
  logic              buf_rd_reg;
  logic              do_push;
  logic              do_pop;
  logic              buf_in_ready;
  logic [DATA_W-1:0] pop_word;

  typedef enum logic {FSFE_SINGLE, FSFE_CHAIN} fsfe_mode_t;

  // Buffer full gates the read side, so a receiver stall stops popping
  assign buf_in_ready = (buf_cnt_reg < 2'(BUF_DEPTH));
  assign do_push = !push_en_n_i && offset_load_n_i && (cnt_reg != CNT_FULL);
  assign do_pop  = !pop_en_n_i && offset_load_n_i && (cnt_reg != CNT_ZERO)
                   && buf_in_ready;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wptr_reg] <= push_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wptr_reg <= PTR_FIRST;
      rptr_reg <= PTR_FIRST;
      cnt_reg  <= CNT_ZERO;
    end else begin
      if (do_push) begin
        wptr_reg <= wptr_reg + 8'h01;
      end
      if (do_pop) begin
        rptr_reg <= rptr_reg + 8'h01;
      end
      if (do_push && !do_pop) begin
        cnt_reg <= cnt_reg + 9'h001;
      end else if (do_pop && !do_push) begin
        cnt_reg <= cnt_reg - 9'h001;
      end
    end
  end

  // Offset registers: empty-side then full-side, alternating per access
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ofs_empty_reg <= ofs_default(DEPTH);
      ofs_full_reg  <= ofs_default(DEPTH);
      ofs_wsel_reg  <= 1'b0;
      ofs_rsel_reg  <= 1'b0;
    end else begin
      if (!offset_load_n_i && !push_en_n_i) begin
        if (ofs_wsel_reg) begin
          ofs_full_reg <= push_data_i[OFS_W-1:0];
        end else begin
          ofs_empty_reg <= push_data_i[OFS_W-1:0];
        end
        ofs_wsel_reg <= !ofs_wsel_reg;
      end
      if (!offset_load_n_i && !pop_en_n_i && buf_in_ready) begin
        ofs_rsel_reg <= !ofs_rsel_reg;
      end
    end
  end

  always_comb begin
    pop_word = mem[rptr_reg];
    if (!offset_load_n_i) begin
      pop_word = {6'h00, (ofs_rsel_reg ? ofs_full_reg : ofs_empty_reg)};
    end
  end

  // Strap caught after release; sticky so chain pulses fall back to half mode only on reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      chain_mode_reg <= FSFE_SINGLE;
    end else begin
      if (wr_chain_in_n_i) begin
        chain_mode_reg <= FSFE_CHAIN;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wchain_reg <= 1'b0;
      rchain_reg <= 1'b0;
    end else begin
      wchain_reg <= do_push && (wptr_reg == PTR_LAST);
      rchain_reg <= do_pop && (rptr_reg == PTR_LAST);
    end
  end

  // Flags follow the count; single clock so both sides update together
  always_comb begin
    queue_empty_n_o = (cnt_reg != CNT_ZERO);
    queue_full_n_o  = (cnt_reg != CNT_FULL);
    near_empty_n_o  = ({3'h0, cnt_reg} > ofs_empty_reg);
    near_full_n_o   = ({3'h0, CNT_FULL - cnt_reg} > ofs_full_reg);
    rd_chain_out_n_o = !rchain_reg;
    if (chain_mode_reg == FSFE_CHAIN) begin
      wr_chain_out_or_half_n_o = !wchain_reg;
    end else begin
      wr_chain_out_or_half_n_o = !(cnt_reg > CNT_HALF);
    end
  end

  // Two-entry output buffer
  logic buf_load;
  logic buf_take;
  assign buf_load = do_pop || (!offset_load_n_i && !pop_en_n_i && buf_in_ready);
  assign buf_take = pop_valid_o && pop_ready_i;
  assign pop_valid_o = (buf_cnt_reg != 2'h0);
  assign pop_data_o  = buf_data[buf_rd_reg];

  always_ff @(posedge clk_i) begin
    if (buf_load) begin
      buf_data[buf_wr_reg] <= pop_word;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      buf_cnt_reg <= 2'h0;
      buf_wr_reg  <= 1'b0;
      buf_rd_reg  <= 1'b0;
    end else begin
      if (buf_load) begin
        buf_wr_reg <= !buf_wr_reg;
      end
      if (buf_take) begin
        buf_rd_reg <= !buf_rd_reg;
      end
      if (buf_load && !buf_take) begin
        buf_cnt_reg <= buf_cnt_reg + 2'h1;
      end else if (buf_take && !buf_load) begin
        buf_cnt_reg <= buf_cnt_reg - 2'h1;
      end
    end
  end

  logic unused_ok;
  assign unused_ok = rd_chain_in_n_i ^ chain_head_n_i;

  AST_EMPTY_NO_POP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !queue_empty_n_o && offset_load_n_i |=> $stable(rptr_reg))
    else $error("pop while empty");
  AST_FULL_NO_PUSH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !queue_full_n_o && !do_pop |=> !queue_full_n_o)
    else $error("push while full");
  AST_EMPTY_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    do_push && !do_pop |=> queue_empty_n_o)
    else $error("empty not cleared");
  AST_NEAR_EMPTY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ({3'h0, cnt_reg} <= ofs_empty_reg) |-> !near_empty_n_o)
    else $error("near empty wrong");
  AST_NEAR_FULL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ({3'h0, CNT_FULL - cnt_reg} <= ofs_full_reg) |-> !near_full_n_o)
    else $error("near full wrong");
  AST_RESET_OFS: assert property (@(posedge clk_i)
    !rst_n_i |=> ofs_empty_reg == OFS_RST_256 && ofs_full_reg == OFS_RST_256)
    else $error("offset default wrong");
  AST_RESET_FLAGS: assert property (@(posedge clk_i)
    !rst_n_i |=> !queue_empty_n_o && queue_full_n_o && !near_empty_n_o && near_full_n_o)
    else $error("reset flags wrong");
  AST_WCHAIN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    do_push && wptr_reg == PTR_LAST |=> wchain_reg ##1 !wchain_reg)
    else $error("write chain pulse");
  AST_RCHAIN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    do_pop && rptr_reg == PTR_LAST |=> !rd_chain_out_n_o)
    else $error("read chain pulse");
  AST_HALF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    chain_mode_reg == FSFE_SINGLE && cnt_reg > CNT_HALF |-> !wr_chain_out_or_half_n_o)
    else $error("half flag wrong");
  AST_FULL_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    do_push && !do_pop && cnt_reg == CNT_FULL - 9'h001 |=> !queue_full_n_o)
    else $error("full not set");
  AST_EMPTY_LAST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    do_pop && !do_push && cnt_reg == 9'h001 |=> !queue_empty_n_o)
    else $error("empty not set");
  AST_LOAD_NO_QUEUE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !offset_load_n_i |=> $stable(wptr_reg) && $stable(rptr_reg) && $stable(cnt_reg))
    else $error("queue moved during offset access");
  AST_RESET_PTR: assert property (@(posedge clk_i)
    !rst_n_i |=> wptr_reg == PTR_FIRST && rptr_reg == PTR_FIRST && cnt_reg == CNT_ZERO)
    else $error("pointers not reset");

  COV_FULL: cover property (@(posedge clk_i) disable iff (!rst_n_i) !queue_full_n_o);
  COV_STALL: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    buf_cnt_reg == 2'h2 && !pop_ready_i);
  COV_LOAD: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    !offset_load_n_i && !push_en_n_i);
endmodule // fsfe_fifo

// *** bench/fsfe_sink.sv ***
`timescale 1ns/1ps
module fsfe_sink (
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        stall_i,
  input  wire logic                        slow_i,
  input  wire logic                        valid_i,
  input  wire logic [fsfe_pkg::DATA_W-1:0] data_i,
  output logic                             ready_o,
  output logic                             got_o,
  output logic [fsfe_pkg::DATA_W-1:0]      got_data_o
);
  import fsfe_pkg::*;
  logic phase_reg;
  always_ff @(posedge clk_i) begin
    phase_reg <= rst_n_i ? !phase_reg : 1'b0;
  end
  // Slow mode takes a word only every other cycle
  assign ready_o = !stall_i && (!slow_i || phase_reg);
  always_ff @(posedge clk_i) begin
    got_o      <= valid_i && ready_o;
    got_data_o <= data_i;
  end
endmodule // fsfe_sink

// *** bench/fsfe_fifo_tb.sv ***
`timescale 1ns/1ps
module fsfe_fifo_tb;
  import fsfe_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              push_n = 1'b1;
  logic              pop_n = 1'b1;
  logic              load_n = 1'b1;
  logic              chain = 1'b0;
  logic              stall = 1'b0;
  logic              slow = 1'b0;
  logic [DATA_W-1:0] din = '0;
  logic [DATA_W-1:0] q, got_d;
  logic              valid, ready, got, emp_n, ful_n, nemp_n, nful_n, wro_n, rdx_n;
  int                fail_count = 0;
  int                samples_checked = 0;
  int                e_ofs = 31;
  int                f_ofs = 31;
  int                wp = 0;
  int                rp = 0;
  always #50 clk = ~clk;
  fsfe_fifo dut (.clk_i(clk), .rst_n_i(rst_n), .push_en_n_i(push_n), .push_data_i(din),
    .pop_en_n_i(pop_n), .offset_load_n_i(load_n), .wr_chain_in_n_i(chain),
    .rd_chain_in_n_i(1'b0), .chain_head_n_i(1'b0), .pop_valid_o(valid), .pop_ready_i(ready),
    .pop_data_o(q), .queue_empty_n_o(emp_n), .queue_full_n_o(ful_n), .near_empty_n_o(nemp_n),
    .near_full_n_o(nful_n), .wr_chain_out_or_half_n_o(wro_n), .rd_chain_out_n_o(rdx_n));
  fsfe_sink sink (.clk_i(clk), .rst_n_i(rst_n), .stall_i(stall), .slow_i(slow),
    .valid_i(valid), .data_i(q), .ready_o(ready), .got_o(got), .got_data_o(got_d));
  // Low cycles counted so a stretched pulse shows up as a count above one
  always @(posedge clk) begin
    if (chain && !wro_n) wp++;
    if (chain && !rdx_n) rp++;
  end
  task automatic cmp(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    cmp({17'h0_0000, g}, {17'h0_0000, e});
  endtask
  task automatic flags(input int n);
    cmp1(emp_n, n != 0);
    cmp1(nemp_n, n > e_ofs);
    cmp1(nful_n, DEPTH - n > f_ofs);
    cmp1(ful_n, n != DEPTH);
    if (!chain) cmp1(wro_n, n <= DEPTH / 2);
  endtask
  function automatic logic [DATA_W-1:0] pat(input int i);
    return DATA_W'(i) ^ 18'h2_AAAA;
  endfunction
  task automatic wr(input logic [DATA_W-1:0] d, input int n, input bit last);
    push_n <= 1'b0;
    din <= d;
    @(posedge clk);
    push_n <= 1'b1;
    @(negedge clk);
    flags(n);
    if (chain) cmp1(wro_n, !last);
    @(posedge clk);
  endtask
  task automatic take(input logic [DATA_W-1:0] d);
    int k;
    k = 0;
    do @(negedge clk); while (got !== 1'b1 && ++k < 8);
    cmp1(got, 1'b1);
    cmp(got_d, d);
  endtask
  task automatic rd(input logic [DATA_W-1:0] d, input int n, input bit last);
    pop_n <= 1'b0;
    @(posedge clk);
    pop_n <= 1'b1;
    @(negedge clk);
    flags(n);
    if (chain) cmp1(rdx_n, !last);
    take(d);
    @(posedge clk);
  endtask
  task automatic t_reset();
    rst_n <= 1'b0;
    e_ofs = 31;
    f_ofs = 31;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    flags(0);
    cmp1(valid, 1'b0);
    @(posedge clk);
  endtask
  task automatic round();
    for (int i = 0; i < DEPTH; i++) wr(pat(i), i + 1, i == DEPTH - 1);
    wr(18'h0_0000, DEPTH, 1'b0);
    for (int i = 0; i < DEPTH; i++) rd(pat(i), DEPTH - 1 - i, i == DEPTH - 1);
  endtask
  task automatic t_chain();
    chain <= 1'b1;
    slow <= 1'b1;
    @(posedge clk);
    round();
    cmp1(wp == 1, 1'b1);
    cmp1(rp == 1, 1'b1);
    chain <= 1'b0;
    slow <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_stall();
    for (int i = 0; i < 3; i++) wr(pat(i), i + 1, 1'b0);
    stall <= 1'b1;
    pop_n <= 1'b0;
    repeat (4) @(posedge clk);
    pop_n <= 1'b1;
    stall <= 1'b0;
    @(negedge clk);
    flags(1);
    take(pat(0));
    take(pat(1));
    @(posedge clk);
    rd(pat(2), 0, 1'b0);
  endtask
  task automatic t_offset();
    load_n <= 1'b0;
    wr(18'h3_F005, 0, 1'b0);
    wr(18'h2_A007, 0, 1'b0);
    rd(18'h0_0005, 0, 1'b0);
    rd(18'h0_0007, 0, 1'b0);
    load_n <= 1'b1;
    e_ofs = 5;
    f_ofs = 7;
    for (int i = 0; i < DEPTH - 6; i++) wr(pat(i), i + 1, 1'b0);
  endtask
  // Mid-run reset must drop the stored words and the programmed offsets
  task automatic t_restart();
    for (int i = 0; i < 40; i++) wr(pat(i + 100), i + 1, 1'b0);
    rd(pat(100), 39, 1'b0);
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    t_reset();
    round();
    t_chain();
    t_reset();
    t_stall();
    t_offset();
    t_reset();
    t_restart();
    report_and_stop();
  end
  initial begin
    #3_000_000;
    fail_count++;
    report_and_stop();
  end
endmodule // fsfe_fifo_tb
